// file: rtl/sync_out_pkg.sv
// Shared constants and carrier types for the output synchronization pulse block.
// Assumes one 200 MHz clock and a byte-wide command link to the host.
`default_nettype none
package sync_out_pkg;
  // ****************************************
  // Command and answer
  // ****************************************
  localparam logic [31:0] CMD_READ_SYNC_OUT = 32'h6f6e7367;
  localparam logic [3:0] ANSWER_LAST = 4'hf;
  localparam logic [3:0] ANSWER_CRC_LO = 4'he;
  localparam logic [3:0] ANSWER_CRC_HI = 4'hf;
  localparam logic [1:0] REQUEST_LAST = 2'h3;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // ****************************************
  // Flag bit positions
  // ****************************************
  localparam int FLAG_FOLLOW = 0;
  localparam int FLAG_FIXED_LEVEL = 1;
  localparam int FLAG_ACTIVE_LOW = 2;
  localparam int FLAG_UNITS_STEPS = 3;
  localparam int FLAG_MOVE_BEGIN = 4;
  localparam int FLAG_MOVE_END = 5;
  localparam int FLAG_PERIODIC = 6;
  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [4:0] ADDR_FLAGS = 5'h00;
  localparam logic [4:0] ADDR_PULSE_LEN = 5'h04;
  localparam logic [4:0] ADDR_INTERVAL = 5'h08;
  localparam logic [4:0] ADDR_WINDOW = 5'h0c;
  localparam logic [4:0] ADDR_WINDOW_MICRO = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PULSE_LEN_RESET = 16'h000a;
  localparam logic [15:0] INTERVAL_RESET = 16'h0064;
  localparam logic [31:0] WINDOW_RESET = 32'h00000000;
  localparam logic [7:0] WINDOW_MICRO_RESET = 8'h00;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int MICROSECOND_NS = 1000;
  localparam int CYCLES_PER_US = MICROSECOND_NS / CLK_PERIOD_NS;
  localparam logic [7:0] US_TICK_LAST = 8'(CYCLES_PER_US - 1);
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0] flags;
    logic [15:0] pulseLen;
    logic [15:0] interval;
    logic [31:0] window;
    logic [7:0] windowMicro;
  } settings_type;
  typedef struct packed {
    logic moving;
    logic stepPulse;
    logic stepper;
    logic signed [31:0] position;
    logic signed [15:0] uPosition;
    logic signed [31:0] target;
    logic signed [15:0] uTarget;
  } motion_type;
  typedef struct packed {
    logic active;
    logic [15:0] remain;
    logic [7:0] prescale;
  } timer_state_type;
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    settings_type cfg;
    settings_type snap;
    logic [23:0] rxWord;
    logic [1:0] rxCount;
    logic rxReady;
    logic sending;
    logic [3:0] idx;
    logic [15:0] crc;
    logic txValid;
    logic [7:0] txData;
    logic movingPrev;
    logic windowPrev;
    logic [15:0] intervalCnt;
    logic syncOut;
  } top_state_type;
endpackage
`default_nettype wire

// file: rtl/answer_checksum.sv
// One byte step of the answer checksum.
// Purely combinational; the caller holds the running value.
`timescale 1ns/10ps
`default_nettype none
module answer_checksum (
  input wire logic [15:0] crcIn,
  input wire logic [7:0] dataByte,
  output logic [15:0] crcOut
);
  // ****************************************
  // Reflected shift, low bit first
  // ****************************************
  always_comb begin
    logic [15:0] c;
    c = crcIn ^ {8'h00, dataByte};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ sync_out_pkg::CRC_POLY) : (c >> 1);
    end
    crcOut = c;
  end
endmodule // answer_checksum
`default_nettype wire

// file: rtl/sync_pulse_timer.sv
// Times one output pulse in microseconds or in steps.
// Assumes stepPulse is a one-cycle strobe per step or encoder pulse.
`timescale 1ns/10ps
`default_nettype none
module sync_pulse_timer (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic trigger,
  input wire logic unitsSteps,
  input wire logic [15:0] length,
  input wire logic stepPulse,
  output logic active
);
  sync_out_pkg::timer_state_type st, next_st;
  logic tick;

  // ****************************************
  // Count down
  // ****************************************
  always_comb begin
    next_st = st;
    tick = unitsSteps ? stepPulse : (st.prescale == sync_out_pkg::US_TICK_LAST);
    if (trigger && length != 16'h0000) begin
      // A new trigger restarts the pulse rather than being lost
      next_st.active = 1'b1;
      next_st.remain = length;
      next_st.prescale = 8'h00;
    end else if (st.active) begin
      next_st.prescale = (tick || unitsSteps) ? 8'h00 : st.prescale + 8'h01;
      if (tick) begin
        next_st.remain = st.remain - 16'h0001;
        if (st.remain == 16'h0001) begin
          next_st.active = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign active = st.active;
endmodule // sync_pulse_timer
`default_nettype wire

// file: rtl/sync_output_pulse_gen.sv
// Output synchronization pulse generator with settings registers and a
// byte-wide settings read command. Assumes one clock, synchronous inputs,
// and a host that holds each Avalon request until waitrequest is low.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - A 4-byte read request returns a 16-byte answer echoing the command.
// - With follow enabled, the pin shows the pulse logic.
// - With follow disabled, the pin sits at the fixed-level flag.
// - Active-low flag inverts the pulse polarity.
// - Step-units flag makes pulse length count steps instead of time.
// - Pulse on movement begin and on movement end when enabled.
// - Periodic flag emits a pulse every interval of step pulses.
// - Pulse length is a 16-bit field, microseconds or steps.
// - Interval is a 16-bit step count between periodic pulses.
// - Positions within the 32-bit window count as target; arrival pulses.
// - The window extends by an 8-bit microstep part, stepper only.
module sync_output_pulse_gen (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  input wire sync_out_pkg::motion_type motion,
  output logic syncOut
);
  sync_out_pkg::top_state_type st, next_st;
  logic [15:0] crcStep;
  logic pulseActive;
  logic inWindow;
  logic beginEvent;
  logic endEvent;
  logic periodEvent;
  logic trigger;
  logic [7:0] status;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] reg_read(input logic [4:0] a, input sync_out_pkg::settings_type c,
      input logic [7:0] s);
    case (a)
      sync_out_pkg::ADDR_FLAGS: reg_read = {24'h000000, c.flags};
      sync_out_pkg::ADDR_PULSE_LEN: reg_read = {16'h0000, c.pulseLen};
      sync_out_pkg::ADDR_INTERVAL: reg_read = {16'h0000, c.interval};
      sync_out_pkg::ADDR_WINDOW: reg_read = c.window;
      sync_out_pkg::ADDR_WINDOW_MICRO: reg_read = {24'h000000, c.windowMicro};
      sync_out_pkg::ADDR_STATUS: reg_read = {24'h000000, s};
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  // Answer layout, little-endian fields after the echoed command
  function automatic logic [7:0] answer_byte(input logic [3:0] i, input sync_out_pkg::settings_type c);
    case (i)
      4'h0: answer_byte = sync_out_pkg::CMD_READ_SYNC_OUT[7:0];
      4'h1: answer_byte = sync_out_pkg::CMD_READ_SYNC_OUT[15:8];
      4'h2: answer_byte = sync_out_pkg::CMD_READ_SYNC_OUT[23:16];
      4'h3: answer_byte = sync_out_pkg::CMD_READ_SYNC_OUT[31:24];
      4'h4: answer_byte = c.flags;
      4'h5: answer_byte = c.pulseLen[7:0];
      4'h6: answer_byte = c.pulseLen[15:8];
      4'h7: answer_byte = c.interval[7:0];
      4'h8: answer_byte = c.interval[15:8];
      4'h9: answer_byte = c.window[7:0];
      4'ha: answer_byte = c.window[15:8];
      4'hb: answer_byte = c.window[23:16];
      4'hc: answer_byte = c.window[31:24];
      4'hd: answer_byte = c.windowMicro;
      default: answer_byte = 8'h00;
    endcase
  endfunction

  function automatic logic within_window(input sync_out_pkg::motion_type m, input sync_out_pkg::settings_type c);
    logic signed [32:0] d;
    logic signed [16:0] du;
    logic [32:0] ad;
    logic [16:0] adu;
    d = 33'(m.position) - 33'(m.target);
    du = 17'(m.uPosition) - 17'(m.uTarget);
    ad = d[32] ? 33'(-d) : 33'(d);
    adu = du[16] ? 17'(-du) : 17'(du);
    if (ad < {1'b0, c.window}) begin
      within_window = 1'b1;
    end else if (ad == {1'b0, c.window}) begin
      // Microstep part only counts on a stepper; DC drives use whole counts
      within_window = !m.stepper || (adu <= {9'h000, c.windowMicro});
    end else begin
      within_window = 1'b0;
    end
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  answer_checksum u_checksum (
    .crcIn(st.crc),
    .dataByte(st.txData),
    .crcOut(crcStep)
  );

  sync_pulse_timer u_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .trigger(trigger),
    .unitsSteps(st.cfg.flags[sync_out_pkg::FLAG_UNITS_STEPS]),
    .length(st.cfg.pulseLen),
    .stepPulse(motion.stepPulse),
    .active(pulseActive)
  );

  // ****************************************
  // Events
  // ****************************************
  always_comb begin
    inWindow = within_window(motion, st.cfg);
    beginEvent = motion.moving && !st.movingPrev;
    // Arrival in the window ends the move even before the drive reports stop
    endEvent = (!motion.moving && st.movingPrev) || (motion.moving && inWindow && !st.windowPrev);
    periodEvent = st.cfg.flags[sync_out_pkg::FLAG_PERIODIC] && motion.moving && motion.stepPulse
        && st.cfg.interval != 16'h0000 && st.intervalCnt + 16'h0001 >= st.cfg.interval;
    trigger = (beginEvent && st.cfg.flags[sync_out_pkg::FLAG_MOVE_BEGIN])
        || (endEvent && st.cfg.flags[sync_out_pkg::FLAG_MOVE_END])
        || periodEvent;
    status = {4'h0, st.sending, motion.moving, inWindow, pulseActive};
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.movingPrev = motion.moving;
    next_st.windowPrev = inWindow;

    if (beginEvent) begin
      next_st.intervalCnt = 16'h0000;
    end else if (periodEvent) begin
      next_st.intervalCnt = 16'h0000;
    end else if (motion.moving && motion.stepPulse) begin
      next_st.intervalCnt = st.intervalCnt + 16'h0001;
    end

    // Avalon slave: one wait cycle, then answer for exactly one cycle
    next_st.waitrequest = !((read || write) && st.waitrequest);
    if (read && st.waitrequest) begin
      next_st.readdata = reg_read(address, st.cfg, status);
    end
    if (write && !st.waitrequest) begin
      case (address)
        sync_out_pkg::ADDR_FLAGS: next_st.cfg.flags = {1'b0, writedata[6:0]};
        sync_out_pkg::ADDR_PULSE_LEN: next_st.cfg.pulseLen = writedata[15:0];
        sync_out_pkg::ADDR_INTERVAL: next_st.cfg.interval = writedata[15:0];
        sync_out_pkg::ADDR_WINDOW: next_st.cfg.window = writedata;
        sync_out_pkg::ADDR_WINDOW_MICRO: next_st.cfg.windowMicro = writedata[7:0];
        default: next_st.cfg = st.cfg;
      endcase
    end

    // Request collection; rxReady is held low, so no byte is taken, while an answer is going out
    if (rxValid && st.rxReady) begin
      next_st.rxWord = {rxData, st.rxWord[23:8]};
      next_st.rxCount = st.rxCount + 2'h1;
      if (st.rxCount == sync_out_pkg::REQUEST_LAST) begin
        next_st.rxCount = 2'h0;
        if ({rxData, st.rxWord} == sync_out_pkg::CMD_READ_SYNC_OUT) begin
          next_st.sending = 1'b1;
          next_st.rxReady = 1'b0;
          // Snapshot keeps the answer coherent if software writes meanwhile
          next_st.snap = st.cfg;
          next_st.idx = 4'h0;
          next_st.crc = sync_out_pkg::CRC_INIT;
          next_st.txValid = 1'b1;
          next_st.txData = answer_byte(4'h0, st.cfg);
        end
      end
    end

    // Answer delivery
    if (st.sending && st.txValid && txReady) begin
      next_st.idx = st.idx + 4'h1;
      if (st.idx < sync_out_pkg::ANSWER_CRC_LO) begin
        next_st.crc = crcStep;
      end
      if (st.idx == sync_out_pkg::ANSWER_LAST) begin
        next_st.sending = 1'b0;
        next_st.txValid = 1'b0;
        next_st.rxReady = 1'b1;
        next_st.idx = 4'h0;
      end else if (st.idx + 4'h1 == sync_out_pkg::ANSWER_CRC_LO) begin
        next_st.txData = crcStep[7:0];
      end else if (st.idx + 4'h1 == sync_out_pkg::ANSWER_CRC_HI) begin
        next_st.txData = st.crc[15:8];
      end else begin
        next_st.txData = answer_byte(st.idx + 4'h1, st.snap);
      end
    end

    // Pin level
    if (st.cfg.flags[sync_out_pkg::FLAG_FOLLOW]) begin
      next_st.syncOut = pulseActive ^ st.cfg.flags[sync_out_pkg::FLAG_ACTIVE_LOW];
    end else begin
      next_st.syncOut = st.cfg.flags[sync_out_pkg::FLAG_FIXED_LEVEL];
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= '0;
      st.waitrequest <= 1'b1;
      st.rxReady <= 1'b1;
      st.crc <= sync_out_pkg::CRC_INIT;
      st.cfg.flags <= sync_out_pkg::FLAGS_RESET;
      st.cfg.pulseLen <= sync_out_pkg::PULSE_LEN_RESET;
      st.cfg.interval <= sync_out_pkg::INTERVAL_RESET;
      st.cfg.window <= sync_out_pkg::WINDOW_RESET;
      st.cfg.windowMicro <= sync_out_pkg::WINDOW_MICRO_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign readdata = st.readdata;
  assign waitrequest = st.waitrequest;
  assign rxReady = st.rxReady;
  assign txValid = st.txValid;
  assign txData = st.txData;
  assign syncOut = st.syncOut;
endmodule // sync_output_pulse_gen
`default_nettype wire

// file: bench/host_link_model.sv
// Host side of the command link: sends 4-byte requests, collects answers.
// Assumes the byte handshake of the block; drops txReady every third clock cycle.
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
  input wire logic ref_clk,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic txReady
);
  // ****************************************
  // Request and answer
  // ****************************************
  logic [7:0] ans [16];
  int got = 0;
  int cyc = 0;
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b0;
  end
  task automatic clear;
    got = 0;
  endtask
  // Low byte first; a released line shows the inverse so no stale byte passes
  task automatic send(input logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      rxValid <= 1'b1;
      rxData <= w[8*i +: 8];
      do @(posedge ref_clk); while (rxReady !== 1'b1);
    end
    rxValid <= 1'b0;
    rxData <= ~w[31:24];
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    txReady <= (cyc % 3) != 0;
    if (txValid && txReady && got < 16) begin
      ans[got] <= txData;
      got <= got + 1;
    end
  end
endmodule // host_link_model
`default_nettype wire

// file: bench/sync_output_pulse_gen_sva.sv
// Checker for the pulse generator, bound to its top module.
// Assumes the flag and length registers change only by bus writes.
`timescale 1ns/10ps
`default_nettype none
module sync_output_pulse_gen_sva (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txReady,
  input wire sync_out_pkg::motion_type motion,
  input wire logic syncOut
);
  // ****************************************
  // Shadow of settings and answer count
  // ****************************************
  logic [7:0] flg;
  logic lenNz;
  logic [4:0] nb;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      flg <= 8'h00;
      lenNz <= 1'b1;
      nb <= 5'h00;
    end else begin
      if (write && !waitrequest && address == sync_out_pkg::ADDR_FLAGS) flg <= writedata[7:0];
      if (write && !waitrequest && address == sync_out_pkg::ADDR_PULSE_LEN) lenNz <= |writedata[15:0];
      if (txValid && txReady) nb <= (nb == 5'h0f) ? 5'h00 : nb + 5'h01;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take; (read || write) && waitrequest; endsequence
  sequence s_beat; txValid && txReady; endsequence
  // Step units excluded: a strobe may end the pulse early
  sequence s_shown; ##2 syncOut != flg[2]; endsequence
  a_bus_answer: assert property (s_take |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");
  a_unmapped_zero: assert property (read && waitrequest && address > 5'h14 |=> readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_flags_read: assert property (read && waitrequest && address == 5'h00 |=> readdata == {25'h0, flg[6:0]})
    else $error("flag read wrong");
  a_answer_head: assert property ($rose(txValid) |-> txData == 8'h67 && !rxReady && nb == 5'h00)
    else $error("answer does not start with command");
  a_answer_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("answer byte not held");
  a_answer_len: assert property (s_beat |=> txValid == (nb != 5'h00))
    else $error("answer length wrong");
  a_rx_blocked: assert property (txValid |-> !rxReady)
    else $error("request accepted during answer");
  a_fixed_pin: assert property (!flg[0] |=> syncOut == $past(flg[1]))
    else $error("fixed pin level wrong");
  a_begin_pulse: assert property ($rose(motion.moving) && flg[0] && flg[4] && !flg[3] && lenNz |-> s_shown)
    else $error("no pulse at move begin");
  a_end_pulse: assert property ($fell(motion.moving) && flg[0] && flg[5] && !flg[3] && lenNz |-> s_shown)
    else $error("no pulse at move end");
endmodule // sync_output_pulse_gen_sva
bind sync_output_pulse_gen sync_output_pulse_gen_sva chk (.ref_clk, .rst_b, .address, .read, .write, .writedata,
  .readdata, .waitrequest, .rxReady, .txValid, .txData, .txReady, .motion, .syncOut);
`default_nettype wire

// file: bench/sync_output_pulse_gen_tb.sv
// Self-checking bench: bus accesses, settings read command, pulse triggers.
// Assumes the checker is bound and the host model drives the command link.
`timescale 1ns/10ps
`default_nettype none
module sync_output_pulse_gen_tb;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata, rd;
  logic waitrequest, rxValid, rxReady, txValid, txReady, syncOut, prev;
  logic [7:0] rxData, txData;
  sync_out_pkg::motion_type motion = '0;
  logic idle = 1'b0;
  logic [15:0] c;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int actCyc = 0;
  int rises = 0;
  logic [4:0] regA [6] = '{sync_out_pkg::ADDR_FLAGS, sync_out_pkg::ADDR_PULSE_LEN, sync_out_pkg::ADDR_INTERVAL,
    sync_out_pkg::ADDR_WINDOW, sync_out_pkg::ADDR_WINDOW_MICRO, 5'h1c};
  logic [31:0] regR [6] = '{32'h0, 32'ha, 32'h64, 32'h0, 32'h0, 32'h0};
  logic [31:0] regW [6] = '{32'hff, 32'h1234abcd, 32'hffff0005, 32'h5, 32'h133, 32'h1};
  logic [31:0] regE [6] = '{32'h7f, 32'habcd, 32'h5, 32'h5, 32'h33, 32'h0};
  logic [7:0] ans [16] = '{8'h67, 8'h73, 8'h6e, 8'h6f, 8'h7f, 8'hcd, 8'hab, 8'h05, 8'h00, 8'h05, 8'h00,
    8'h00, 8'h00, 8'h33, 8'h00, 8'h00};
  always #2.5 ref_clk = ~ref_clk;
  sync_output_pulse_gen dut (.ref_clk, .rst_b, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .rxValid, .rxData, .rxReady, .txValid, .txData, .txReady, .motion, .syncOut);
  host_link_model host (.ref_clk, .rxReady, .txValid, .txData, .rxValid, .rxData, .txReady);
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prev <= syncOut;
    if (syncOut !== idle) actCyc <= actCyc + 1;
    if (syncOut !== idle && prev === idle) rises <= rises + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Counters cleared only after the flag change has reached the pin
  task automatic arm(input logic [7:0] fl, input logic [15:0] len);
    bus(1'b1, sync_out_pkg::ADDR_PULSE_LEN, {16'h0000, len});
    bus(1'b1, sync_out_pkg::ADDR_FLAGS, {24'h000000, fl});
    idle = fl[sync_out_pkg::FLAG_ACTIVE_LOW];
    repeat (3) @(posedge ref_clk);
    actCyc = 0;
    rises = 0;
  endtask
  task automatic tally(input string what, input int n, input int cy, input int r);
    repeat (n) @(posedge ref_clk);
    check({what, " cycles"}, actCyc, cy);
    check({what, " pulses"}, rises, r);
  endtask
  task automatic step(input int gap);
    motion.stepPulse <= 1'b1;
    @(posedge ref_clk);
    motion.stepPulse <= 1'b0;
    repeat (gap) @(posedge ref_clk);
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] b [16]);
    logic [15:0] r;
    r = 16'hffff;
    for (int i = 0; i < 14; i++) begin
      r = r ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
    end
    return r;
  endfunction
  initial begin
    motion.target <= 32'h000003e8;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, regA[i], 32'h0);
      check("reset value", rd, regR[i]);
    end
    for (int i = 0; i < 6; i++) bus(1'b1, regA[i], regW[i]);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, regA[i], 32'h0);
      check("readback", rd, regE[i]);
    end
    c = crc16(ans);
    ans[14] = c[7:0];
    ans[15] = c[15:8];
    host.send(sync_out_pkg::CMD_READ_SYNC_OUT);
    while (host.got < 16) @(posedge ref_clk);
    for (int i = 0; i < 16; i++) check("answer byte", host.ans[i], ans[i]);
    host.clear();
    host.send(32'h6f6e7368);
    repeat (40) @(posedge ref_clk);
    check("stray answer", host.got, 32'h0);
    arm(8'h02, 16'h0001);
    check("fixed high", syncOut, 32'h1);
    arm(8'h00, 16'h0001);
    check("fixed low", syncOut, 32'h0);
    arm(8'h11, 16'h0002);
    motion.moving <= 1'b1;
    tally("begin", 600, 400, 1);
    arm(8'h21, 16'h0001);
    motion.position <= 32'h000003e5;
    tally("window", 300, 200, 1);
    arm(8'h25, 16'h0002);
    motion.moving <= 1'b0;
    tally("end low", 600, 400, 1);
    // Edge of the window: the microstep part decides only on a stepper
    motion.position <= 32'h000003e3;
    motion.uPosition <= 16'h0040;
    motion.stepper <= 1'b1;
    bus(1'b0, sync_out_pkg::ADDR_STATUS, 32'h0);
    check("micro outside", rd, 32'h0);
    motion.uPosition <= 16'h0020;
    bus(1'b0, sync_out_pkg::ADDR_STATUS, 32'h0);
    check("micro inside", rd, 32'h2);
    motion.uPosition <= 16'h0040;
    motion.stepper <= 1'b0;
    bus(1'b0, sync_out_pkg::ADDR_STATUS, 32'h0);
    check("whole counts", rd, 32'h2);
    // The strobe that starts the move also triggers, so it is not counted
    arm(8'h19, 16'h0002);
    motion.position <= 32'h00000000;
    motion.moving <= 1'b1;
    step(9);
    step(9);
    check("step pulse on", syncOut, 32'h1);
    bus(1'b0, sync_out_pkg::ADDR_STATUS, 32'h0);
    check("status active", rd, 32'h5);
    step(9);
    check("step pulse off", syncOut, 32'h0);
    motion.moving <= 1'b0;
    bus(1'b1, sync_out_pkg::ADDR_INTERVAL, 32'h4);
    arm(8'h41, 16'h0001);
    motion.moving <= 1'b1;
    repeat (9) step(249);
    tally("periodic", 300, 400, 2);
    test_done;
  end
endmodule // sync_output_pulse_gen_tb
`default_nettype wire
